//--- verilog/fsc_consts.svh
// Offsets, field positions, reset values and link constants of the flash timing and signature block.
// Overview of operation
// R1: Flash access lasts access field plus one clocks.
// R2: Code zero: one clock, system clock up to 20 MHz.
// R3: Code one: two clocks, up to 40 MHz.
// R4: Code two: three clocks, 72 MHz; three reserved.
// R5: Software writes config upper bits back unchanged.
// R6: Software matches access time to clock frequency.
// R7: Start register holds 17-bit word location, resets zero.
// R8: Stop register holds 17-bit word location, resets zero.
// R9: Range locations are byte address divided by sixteen.
// R10: Writing stop bit 17 launches signature generation.
// R11: Generator stays idle while launch bit is zero.
// R12: Stop location and launch accepted in one write.
// R13: Config 0x010, start 0x020, stop 0x024 decode.
// R14: Read-only status at 0xFE0, resets to zero.
// R15: Write-only clear at 0xFE8 affects only status.
// R16: Reserved bits written zero, read undefined.
// R17: Result words 0x02C to 0x038 give signature slices.
// R18: Signature shifts, XORs word, feeds taps into 127.
// R19: Completion sets status bit 2 until cleared.
// R20: Writing clear bit 2 clears the completion flag.
// R21: Flash reads stall while generation is running.
// R22: Generator runs alone; results update only when complete.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
`define FSC_BASE_ADDR 32'h4003_C000
`define FSC_OFF_CFG 12'h010
`define FSC_OFF_START 12'h020
`define FSC_OFF_STOP 12'h024
`define FSC_OFF_W0 12'h02C
`define FSC_OFF_W1 12'h030
`define FSC_OFF_W2 12'h034
`define FSC_OFF_W3 12'h038
`define FSC_OFF_STAT 12'hFE0
`define FSC_OFF_STATCLR 12'hFE8
`define FSC_WAIT_LSB 0
`define FSC_WAIT_MSB 1
`define FSC_LOC_MSB 16
`define FSC_LAUNCH_BIT 17
`define FSC_DONE_BIT 2
`define FSC_WAIT_RESET 2'h2
`define FSC_LOC_RESET 17'h0_0000
`define FSC_TAP_A 0
`define FSC_TAP_B 2
`define FSC_TAP_C 27
`define FSC_TAP_D 29
`define FSC_APB_ADDR 12'h000
`define FSC_APB_WDATA 12'h004
`define FSC_APB_CTRL 12'h008
`define FSC_APB_STAT 12'h00C
`define FSC_APB_RDATA 12'h010
`define FSC_CTRL_GO_BIT 0
`define FSC_CTRL_WR_BIT 1
`define FSC_STAT_BUSY_BIT 0
`endif

//--- verilog/fsc_pkg.sv
// Types shared by both ends of the flash timing and signature block.
`default_nettype none
package fsc_pkg;
    typedef logic [11:0] fsc_off_t;
    typedef logic [31:0] fsc_word_t;
    typedef logic [127:0] fsc_sig_t;
    typedef logic [16:0] fsc_loc_t;
    typedef enum logic [1:0] {FSC_IDLE, FSC_CPU, FSC_SCAN} fsc_state_t;
endpackage : fsc_pkg
`default_nettype wire

//--- verilog/fsc_link_if.sv
// Register port joining the controller end to the flash register block.
`timescale 1ns/1ps
`default_nettype none
interface fsc_link_if;
    import fsc_pkg::*;
    logic req;
    logic we;
    fsc_off_t addr;
    fsc_word_t wdata;
    fsc_word_t rdata;
    logic ack;
    modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
    modport ctl (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : fsc_link_if
`default_nettype wire

//--- verilog/fsc_flash_ctrl.sv
// Flash register block: access timing, signature range, generator and status.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_flash_ctrl #(
    parameter int WAIT_W = 2
) (
    input wire logic mclk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    fsc_link_if.dev link, // Register port.
    input wire logic cpu_rd_req, // Processor flash read request, held until ack.
    input wire fsc_pkg::fsc_loc_t cpu_rd_loc, // Flash word location to read.
    output logic cpu_rd_ack, // One-cycle pulse, read data valid.
    output fsc_pkg::fsc_sig_t cpu_rd_data, // Flash word returned to the processor.
    output fsc_pkg::fsc_loc_t flash_loc, // Location driven to the flash array.
    input wire fsc_pkg::fsc_sig_t flash_word, // Array data for flash_loc.
    output logic sig_busy // High while the generator scans.
);
    import fsc_pkg::*;

    fsc_state_t state_r;
    logic [WAIT_W-1:0] access_wait_cycles_r;
    logic [29:0] cfg_upper_r;
    fsc_loc_t start_r;
    fsc_loc_t stop_r;
    logic sig_launch_r;
    logic sig_complete_flag_r;
    fsc_sig_t sig_acc_r;
    fsc_sig_t sig_result_r;
    logic [WAIT_W-1:0] wait_cnt_r;
    fsc_loc_t flash_loc_r;
    fsc_word_t rdata_r;
    logic ack_r;
    logic take;
    logic scan_last;
    logic launch_go;
    logic sig_busy_r;

    // The two-cycle request/ack protocol: the cycle carrying ack is not a new request.
    assign take = link.req && !ack_r;
    assign scan_last = (state_r == FSC_SCAN) && (flash_loc_r == stop_r);
    assign launch_go = (state_r == FSC_IDLE) && sig_launch_r;

    function automatic fsc_sig_t fold(input fsc_sig_t s, input fsc_sig_t d);
        fold = {d[127] ^ s[`FSC_TAP_A] ^ s[`FSC_TAP_B] ^ s[`FSC_TAP_C] ^ s[`FSC_TAP_D],
                d[126:0] ^ s[127:1]}; // R18
    endfunction : fold

    function automatic logic hit(input fsc_off_t a, input fsc_off_t off);
        hit = (a == off);
    endfunction : hit

    // Configuration: upper bits are stored so a read-modify-write returns them unchanged.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            access_wait_cycles_r <= WAIT_W'(`FSC_WAIT_RESET);
            cfg_upper_r <= 30'h0000_0000;
        end else if (take && link.we && hit(link.addr, `FSC_OFF_CFG)) begin // R13
            access_wait_cycles_r <= link.wdata[`FSC_WAIT_MSB:`FSC_WAIT_LSB]; // R2 R3 R4
            cfg_upper_r <= link.wdata[31:2]; // R5
        end
    end

    // Range registers; the range is frozen while a scan runs.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_r <= `FSC_LOC_RESET; // R7
            stop_r <= `FSC_LOC_RESET; // R8
        end else if (take && link.we && state_r != FSC_SCAN) begin
            if (hit(link.addr, `FSC_OFF_START)) begin
                start_r <= link.wdata[`FSC_LOC_MSB:0]; // R7 R9
            end
            if (hit(link.addr, `FSC_OFF_STOP)) begin
                stop_r <= link.wdata[`FSC_LOC_MSB:0]; // R8 R12
            end
        end
    end

    // Launch bit stays high from the write until the scan has finished.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sig_launch_r <= 1'b0;
        end else if (scan_last) begin
            sig_launch_r <= 1'b0;
        end else if (take && link.we && hit(link.addr, `FSC_OFF_STOP) && state_r != FSC_SCAN) begin
            sig_launch_r <= link.wdata[`FSC_LAUNCH_BIT]; // R10 R12
        end
    end

    // Completion flag: the set beats a clear arriving in the same cycle.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sig_complete_flag_r <= 1'b0; // R14
        end else if (scan_last) begin
            sig_complete_flag_r <= 1'b1; // R19
        end else if (take && link.we && hit(link.addr, `FSC_OFF_STATCLR)
                     && link.wdata[`FSC_DONE_BIT]) begin
            sig_complete_flag_r <= 1'b0; // R15 R20
        end
    end

    // Sequencer shared by processor reads and the signature scan.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= FSC_IDLE;
            flash_loc_r <= `FSC_LOC_RESET;
            wait_cnt_r <= '0;
            sig_busy_r <= 1'b0;
        end else begin
            unique case (state_r)
                FSC_IDLE: begin
                    if (launch_go) begin // R11
                        state_r <= FSC_SCAN; // R22
                        sig_busy_r <= 1'b1;
                        flash_loc_r <= start_r;
                    end else if (cpu_rd_req && !cpu_rd_ack) begin // R21
                        // The requester still holds its request in the answer cycle.
                        state_r <= FSC_CPU;
                        flash_loc_r <= cpu_rd_loc;
                        wait_cnt_r <= access_wait_cycles_r; // R1
                    end
                end
                FSC_CPU: begin
                    if (wait_cnt_r == '0) begin
                        state_r <= FSC_IDLE; // R1
                    end else begin
                        wait_cnt_r <= wait_cnt_r - 1'b1;
                    end
                end
                FSC_SCAN: begin
                    if (scan_last) begin
                        state_r <= FSC_IDLE;
                        sig_busy_r <= 1'b0;
                    end else begin
                        flash_loc_r <= flash_loc_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Processor read answer; requests simply wait until the sequencer is back in idle after a scan.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_rd_ack <= 1'b0;
            cpu_rd_data <= '0;
        end else begin
            cpu_rd_ack <= (state_r == FSC_CPU) && (wait_cnt_r == '0); // R21
            if ((state_r == FSC_CPU) && (wait_cnt_r == '0)) begin
                cpu_rd_data <= flash_word;
            end
        end
    end

    // Signature accumulation; visible results change only at the end of a scan.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sig_acc_r <= '0;
            sig_result_r <= '0;
        end else if (launch_go) begin
            sig_acc_r <= '0; // R18
        end else if (state_r == FSC_SCAN) begin
            sig_acc_r <= fold(sig_acc_r, flash_word); // R18
            if (scan_last) begin
                sig_result_r <= fold(sig_acc_r, flash_word); // R22
            end
        end
    end

    // Register reads; reserved bits read as zero except config bits 31:2, which return the stored upper bits; unmapped offsets read as zero.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= take;
            if (take) begin
                unique case (link.addr)
                    `FSC_OFF_CFG: rdata_r <= {cfg_upper_r, access_wait_cycles_r};
                    `FSC_OFF_START: rdata_r <= {15'h0000, start_r}; // R16
                    `FSC_OFF_STOP: rdata_r <= {14'h0000, sig_launch_r, stop_r};
                    `FSC_OFF_W0: rdata_r <= sig_result_r[31:0]; // R17
                    `FSC_OFF_W1: rdata_r <= sig_result_r[63:32]; // R17
                    `FSC_OFF_W2: rdata_r <= sig_result_r[95:64]; // R17
                    `FSC_OFF_W3: rdata_r <= sig_result_r[127:96]; // R17
                    `FSC_OFF_STAT: rdata_r <= 32'(sig_complete_flag_r) << `FSC_DONE_BIT; // R14
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign link.ack = ack_r;
    assign link.rdata = rdata_r;
    assign flash_loc = flash_loc_r;
    assign sig_busy = sig_busy_r;
endmodule : fsc_flash_ctrl
`default_nettype wire

//--- verilog/fsc_apb_master_end.sv
// Controller end: APB slave registers that drive transfers on the register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_apb_master_end (
    input wire logic mclk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error, always low.
    fsc_link_if.ctl link // Register port toward the flash block.
);
    import fsc_pkg::*;

    fsc_off_t tgt_addr_r;
    fsc_word_t tgt_wdata_r;
    fsc_word_t tgt_rdata_r;
    logic tgt_we_r;
    logic req_r;
    logic apb_wr;
    fsc_off_t poff;

    assign poff = paddr[11:0];
    assign apb_wr = psel && penable && pready && pwrite;

    // Answer in the first access cycle; data is set up during the setup cycle.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable && !pwrite) begin
                unique case (poff)
                    `FSC_APB_ADDR: prdata <= {20'h0_0000, tgt_addr_r};
                    `FSC_APB_WDATA: prdata <= tgt_wdata_r;
                    `FSC_APB_STAT: prdata <= 32'(req_r) << `FSC_STAT_BUSY_BIT;
                    `FSC_APB_RDATA: prdata <= tgt_rdata_r;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Order registers; they are frozen while a transfer is in flight.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tgt_addr_r <= 12'h000;
            tgt_wdata_r <= 32'h0000_0000;
            tgt_we_r <= 1'b0;
        end else if (apb_wr && !req_r) begin
            if (poff == `FSC_APB_ADDR) begin
                tgt_addr_r <= pwdata[11:0]; // R13
            end
            if (poff == `FSC_APB_WDATA) begin
                tgt_wdata_r <= pwdata; // R5 R16
            end
            if (poff == `FSC_APB_CTRL) begin
                tgt_we_r <= pwdata[`FSC_CTRL_WR_BIT];
            end
        end
    end

    // Request held until the block acks; a go while busy is ignored.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_r <= 1'b0;
            tgt_rdata_r <= 32'h0000_0000;
        end else if (req_r) begin
            if (link.ack) begin
                req_r <= 1'b0;
                if (!tgt_we_r) begin
                    tgt_rdata_r <= link.rdata;
                end
            end
        end else if (apb_wr && poff == `FSC_APB_CTRL && pwdata[`FSC_CTRL_GO_BIT]) begin
            req_r <= 1'b1;
        end
    end

    assign link.req = req_r;
    assign link.we = tgt_we_r;
    assign link.addr = tgt_addr_r;
    assign link.wdata = tgt_wdata_r;
endmodule : fsc_apb_master_end
`default_nettype wire

//--- test/fsc_link_monitor.sv
// Concurrent checks on the register port and flash side of the signature block.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_link_monitor (
    input wire logic mclk, // System clock.
    input wire logic rst, // Reset, active high.
    input wire logic req, // Port request.
    input wire logic we, // Port direction.
    input wire fsc_pkg::fsc_off_t addr, // Port offset.
    input wire fsc_pkg::fsc_word_t wdata, // Port write data.
    input wire fsc_pkg::fsc_word_t rdata, // Port read data.
    input wire logic ack, // Port answer.
    input wire logic cpu_rd_req, // Processor read request.
    input wire logic cpu_rd_ack, // Processor read answer.
    input wire fsc_pkg::fsc_loc_t flash_loc, // Array location.
    input wire logic sig_busy // Generator running.
);
    import fsc_pkg::*;
    logic [1:0] wait_r;
    fsc_loc_t start_r;
    fsc_loc_t stop_r;
    fsc_loc_t span_r;
    logic [7:0] rd_cnt_r;
    logic launch_w;
    assign launch_w = ack && we && addr == `FSC_OFF_STOP && wdata[`FSC_LAUNCH_BIT];
    // Register writes are mirrored at the answer cycle, while the request is still held.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_r <= `FSC_WAIT_RESET;
            start_r <= '0;
            stop_r <= '0;
        end else if (ack && we) begin
            if (addr == `FSC_OFF_CFG) wait_r <= wdata[1:0];
            if (addr == `FSC_OFF_START) start_r <= wdata[16:0];
            if (addr == `FSC_OFF_STOP) stop_r <= wdata[16:0];
        end
    end
    // Stalled cycles are not counted, so a read held off by a scan still sees the exact latency.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_cnt_r <= 8'h00;
            span_r <= 17'h0_0000;
        end else begin
            rd_cnt_r <= !cpu_rd_req ? 8'h00 : rd_cnt_r + {7'h00, !sig_busy && !cpu_rd_ack};
            span_r <= sig_busy ? span_r + 17'h0_0001 : 17'h0_0000;
        end
    end
    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_ACK_NEXT: assert property (req && !ack |=> ack)
        else $error("port answer missing one cycle after request");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("port answer longer than one cycle");
    AST_RDATA_HOLD: assert property (!(req && !ack) |=> $stable(rdata))
        else $error("port read data changed without request");
    AST_READ_LATENCY: assert property (cpu_rd_ack |-> rd_cnt_r == {6'h00, wait_r} + 8'h02)
        else $error("flash read latency differs from access field");
    AST_NO_ACK_SCAN: assert property (sig_busy |-> !cpu_rd_ack)
        else $error("flash read answered during scan");
    AST_LAUNCH_GO: assert property (launch_w |=> sig_busy)
        else $error("launch write did not start the scan");
    AST_IDLE_HOLD: assert property ($rose(sig_busy) |-> $past(launch_w))
        else $error("scan started without launch write");
    AST_FIRST_LOC: assert property ($rose(sig_busy) |-> flash_loc == start_r)
        else $error("scan did not begin at start location");
    AST_SPAN: assert property ($fell(sig_busy) |-> span_r == stop_r - start_r + 17'h0_0001)
        else $error("scan length differs from range");
endmodule : fsc_link_monitor
`default_nettype wire

//--- test/flash_timing_and_signature_ctrl_test.sv
// Self-checking bench joining the APB controller end to the flash signature block.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module flash_timing_and_signature_ctrl_test;
    import fsc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_rd_req = 1'b0;
    fsc_loc_t cpu_rd_loc = 17'h0_0000;
    logic cpu_rd_ack;
    fsc_sig_t cpu_rd_data;
    fsc_loc_t flash_loc;
    fsc_sig_t flash_word;
    logic sig_busy;
    int fails = 0;
    int checks = 0;
    fsc_word_t rnd = 32'h0000_0058;
    fsc_word_t key = 32'h0000_0000;
    string nq[$];
    fsc_sig_t eq[$];
    string cn;
    fsc_sig_t ce;
    fsc_sig_t cg;
    fsc_link_if link ();
    fsc_apb_master_end u_fsc_apb_master_end (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    fsc_flash_ctrl u_fsc_flash_ctrl (.mclk(mclk), .rst(rst), .link(link),
        .cpu_rd_req(cpu_rd_req), .cpu_rd_loc(cpu_rd_loc), .cpu_rd_ack(cpu_rd_ack),
        .cpu_rd_data(cpu_rd_data), .flash_loc(flash_loc), .flash_word(flash_word),
        .sig_busy(sig_busy));
    fsc_link_monitor u_fsc_link_monitor (.mclk(mclk), .rst(rst), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .cpu_rd_req(cpu_rd_req), .cpu_rd_ack(cpu_rd_ack), .flash_loc(flash_loc),
        .sig_busy(sig_busy));
    always #5 mclk = ~mclk;
    function automatic fsc_word_t lfsr(input fsc_word_t x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic fsc_sig_t fw(input fsc_loc_t l);
        return {4{key[14:0] ^ l[14:0], l}};
    endfunction : fw
    // The array is combinational, so data follows the location in the same cycle.
    always_comb flash_word = fw(flash_loc);
    function automatic fsc_sig_t sig(input fsc_loc_t a, input fsc_loc_t b);
        fsc_sig_t s;
        s = '0;
        for (int i = 0; i <= int'(b - a); i++) begin
            s = (s >> 1) ^ fw(a + i[16:0]) ^ {s[0] ^ s[2] ^ s[27] ^ s[29], {127{1'b0}}};
        end
        return s;
    endfunction : sig
    task automatic apb(input logic w, input fsc_off_t a, input fsc_word_t d, output fsc_word_t r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0_0000, a};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic dev(input logic w, input fsc_off_t o, input fsc_word_t d, output fsc_word_t r);
        apb(1'b1, `FSC_APB_ADDR, {20'h0_0000, o}, r);
        apb(1'b1, `FSC_APB_WDATA, d, r);
        apb(1'b1, `FSC_APB_CTRL, {30'h0000_0000, w, 1'b1}, r);
        do begin
            apb(1'b0, `FSC_APB_STAT, 32'h0000_0000, r);
        end while (r[0] !== 1'b0);
        if (!w) apb(1'b0, `FSC_APB_RDATA, 32'h0000_0000, r);
    endtask : dev
    task automatic rd(input fsc_off_t o, input fsc_word_t e, input string n);
        fsc_word_t r;
        nq.push_back(n);
        eq.push_back({96'h0, e});
        dev(1'b0, o, 32'h0000_0000, r);
    endtask : rd
    task automatic cpu_read(input fsc_loc_t l);
        nq.push_back("flash word");
        eq.push_back(fw(l));
        @(posedge mclk);
        cpu_rd_req <= 1'b1;
        cpu_rd_loc <= l;
        do begin
            @(posedge mclk);
        end while (cpu_rd_ack !== 1'b1);
        cpu_rd_req <= 1'b0;
    endtask : cpu_read
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            `CHK("slave error", 1'b0, pslverr)
        end
        if (eq.size() != 0 && (cpu_rd_ack === 1'b1 || (psel && penable && pready === 1'b1
                && !pwrite && paddr == 32'h0000_0010))) begin
            cn = nq.pop_front();
            ce = eq.pop_front();
            cg = cpu_rd_ack === 1'b1 ? cpu_rd_data : {96'h0, prdata};
            `CHK(cn, ce, cg)
        end
    end
    initial begin
        fsc_word_t r;
        fsc_loc_t s;
        fsc_loc_t e;
        fsc_sig_t sg;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rnd = lfsr(rnd);
        key = rnd;
        rd(`FSC_OFF_CFG, 32'h0000_0002, "config");
        rd(`FSC_OFF_START, 32'h0000_0000, "start");
        rd(`FSC_OFF_STOP, 32'h0000_0000, "stop");
        rd(`FSC_OFF_STAT, 32'h0000_0000, "status");
        rd(12'h100, 32'h0000_0000, "unmapped");
        $display("test reset values done");
        for (int c = 0; c < 3; c++) begin
            rnd = lfsr(rnd);
            dev(1'b1, `FSC_OFF_CFG, {30'h0000_0000, c[1:0]}, r);
            rd(`FSC_OFF_CFG, {30'h0000_0000, c[1:0]}, "config");
            cpu_read(rnd[20:4]);
        end
        $display("test access time done");
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            s = rnd[16:0];
            e = s + (k == 0 ? 17'h0_0028 : 17'h0_0000);
            sg = sig(s, e);
            dev(1'b1, `FSC_OFF_START, {15'h0000, s}, r);
            dev(1'b1, `FSC_OFF_STOP, {14'h0000, 1'b1, e}, r);
            cpu_read(e);
            rd(`FSC_OFF_STAT, 32'h0000_0004, "status");
            for (int j = 0; j < 4; j++) begin
                rd(`FSC_OFF_W0 + fsc_off_t'(4 * j), sg[32 * j +: 32], "result");
            end
            rd(`FSC_OFF_STOP, {15'h0000, e}, "stop");
            rd(`FSC_OFF_STATCLR, 32'h0000_0000, "clear");
            dev(1'b1, `FSC_OFF_STATCLR, 32'h0000_0004, r);
            rd(`FSC_OFF_STAT, 32'h0000_0000, "status");
            rd(`FSC_OFF_START, {15'h0000, s}, "start");
        end
        $display("test signature done");
        test_done();
    end
    // The whole sequence needs under a thousand cycles; this limit leaves ample margin.
    initial begin
        #300us;
        fails++;
        test_done();
    end
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
endmodule : flash_timing_and_signature_ctrl_test
`default_nettype wire
